// ---- hdl/ccb_ctrl.sv ----
// file: capture channel b control register, channel reset and capture blocking logic
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module ccb_ctrl (
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   input  wire ccb_pkg::ccb_axi_req_t axi_req,
   output ccb_pkg::ccb_axi_rsp_t      axi_rsp,
   input  wire logic                  frame_start,
   input  wire logic                  field_start,
   input  wire ccb_pkg::ccb_evt_t     cap_evt,
   input  wire logic                  dma_pending,
   input  wire logic                  evt_request,
   output logic                       dma_event,
   output logic                       fifo_flush,
   output logic                       capture_channel_enable,
   output logic [31:0]                capture_b_control_reg,
   output logic                       irq
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [31:0]        ctrl;
      logic [2:0]         stat;
      logic [3:0]         irq_stat;
      logic [3:0]         irq_mask;
      ccb_pkg::ccb_mode_t mode;
      logic               gate;
      logic               frm_prev;
      logic               fld_prev;
      logic               flush;
      logic               aw_hold;
      logic [7:0]         aw_addr;
      logic               w_hold;
      logic [31:0]        w_data;
      logic [3:0]         w_strb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
   } ccb_state_t;

   ccb_state_t s_q;
   ccb_state_t s_d;
   logic [1:0] pins_sync;

   // frame and field starts come from the pixel clock side
   ccb_sync #(
      .W (2)
   ) u_sync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .d        ({frame_start, field_start}),
      .q        (pins_sync)
   );

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic mapped(input logic [7:0] a);
      return a == ccb_pkg::CTRL_OFS || a == ccb_pkg::STAT_OFS ||
             a == ccb_pkg::IRQ_STAT_OFS || a == ccb_pkg::IRQ_MASK_OFS;
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////////////
   logic        frm_rise;
   logic        fld_rise;
   logic        blocked;
   logic        do_wr;
   logic        do_rd;
   logic [31:0] wv;
   logic [3:0]  evt_v;

   assign frm_rise = pins_sync[1] & ~s_q.frm_prev;
   assign fld_rise = pins_sync[0] & ~s_q.fld_prev;
   assign blocked  = s_q.ctrl[ccb_pkg::BLK_BIT];
   assign do_wr    = s_q.aw_hold & s_q.w_hold & ~s_q.bvalid;
   assign do_rd    = axi_req.arvalid & ~s_q.rvalid;
   assign evt_v    = {cap_evt.f1_done, cap_evt.f2_done, cap_evt.frm_done, cap_evt.vert};

   always_comb begin
      s_d          = s_q;
      s_d.frm_prev = pins_sync[1];
      s_d.fld_prev = pins_sync[0];
      s_d.flush    = 1'b0;
      wv           = merge(s_q.ctrl, s_q.w_data, s_q.w_strb);

      // write address and data are taken in either order
      if (axi_req.awvalid && !s_q.aw_hold) begin
         s_d.aw_hold = 1'b1;
         s_d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s_q.w_hold) begin
         s_d.w_hold = 1'b1;
         s_d.w_data = axi_req.wdata;
         s_d.w_strb = axi_req.wstrb;
      end
      if (s_q.bvalid && axi_req.bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.rvalid && axi_req.rready) begin
         s_d.rvalid = 1'b0;
      end

      // hardware events: set wins over a read clear, done below after the clear
      if (do_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = mapped(axi_req.araddr) ? ccb_pkg::RESP_OKAY : ccb_pkg::RESP_SLVERR;
         case (axi_req.araddr)
            ccb_pkg::CTRL_OFS:     s_d.rdata = s_q.ctrl;
            ccb_pkg::STAT_OFS:     s_d.rdata = {29'h0, s_q.stat};
            ccb_pkg::IRQ_STAT_OFS: begin
               s_d.rdata    = {28'h0, s_q.irq_stat};
               s_d.irq_stat = 4'h0;
            end
            ccb_pkg::IRQ_MASK_OFS: s_d.rdata = {28'h0, s_q.irq_mask};
            default:               s_d.rdata = 32'h0;
         endcase
      end

      if (do_wr) begin
         s_d.aw_hold = 1'b0;
         s_d.w_hold  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = mapped(s_q.aw_addr) ? ccb_pkg::RESP_OKAY : ccb_pkg::RESP_SLVERR;
         case (s_q.aw_addr)
            ccb_pkg::CTRL_OFS: begin
               // request bit only sets from software, zero is ignored
               s_d.ctrl = (wv & ccb_pkg::CTRL_WMASK) |
                          (s_q.ctrl & (32'h1 << ccb_pkg::REQ_BIT)) |
                          (wv & (32'h1 << ccb_pkg::REQ_BIT));
               if (s_q.mode != ccb_pkg::CCB_RUN) begin
                  s_d.ctrl[ccb_pkg::REQ_BIT] = 1'b1;
               end
               if (wv[ccb_pkg::BLK_BIT] && !blocked) begin
                  s_d.gate = 1'b0;
               end
            end
            ccb_pkg::STAT_OFS:     s_d.stat     = s_q.stat & ~s_q.w_data[2:0];
            ccb_pkg::IRQ_MASK_OFS: s_d.irq_mask = s_q.w_data[3:0];
            default: ;
         endcase
      end

      // done flags and interrupt status not set by events while blocked
      if (!blocked) begin
         s_d.stat     = s_d.stat | evt_v[3:1];
         s_d.irq_stat = s_d.irq_stat | evt_v;
      end

      // blocking holds events off until the next frame start
      if (blocked) begin
         s_d.gate = 1'b0;
      end else if (frm_rise) begin
         s_d.gate = 1'b1;
      end

      case (s_q.mode)
         ccb_pkg::CCB_RUN: begin
            if (s_q.ctrl[ccb_pkg::REQ_BIT]) begin
               s_d.mode = ccb_pkg::CCB_DRAIN;
               s_d.gate = 1'b0;
               s_d.ctrl[ccb_pkg::EN_BIT] = 1'b0;
            end
         end
         ccb_pkg::CCB_DRAIN: begin
            s_d.gate = 1'b0;
            if (!dma_pending) begin
               s_d.mode  = ccb_pkg::CCB_FLUSH;
               s_d.flush = 1'b1;
            end
         end
         ccb_pkg::CCB_FLUSH: begin
            s_d.mode     = ccb_pkg::CCB_WAIT;
            s_d.ctrl     = ccb_pkg::CTRL_RESET | (32'h1 << ccb_pkg::REQ_BIT);
            s_d.stat     = ccb_pkg::STAT_RESET;
            s_d.irq_stat = ccb_pkg::IRQ_RESET;
            s_d.irq_mask = ccb_pkg::IRQ_RESET;
            s_d.gate     = 1'b0;
         end
         ccb_pkg::CCB_WAIT: begin
            s_d.mode = ccb_pkg::CCB_RUN;
            s_d.ctrl[ccb_pkg::REQ_BIT] = 1'b0;
         end
         default: s_d.mode = ccb_pkg::CCB_RUN;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_q          <= '0;
         s_q.ctrl     <= ccb_pkg::CTRL_RESET;
         s_q.stat     <= ccb_pkg::STAT_RESET;
         s_q.irq_stat <= ccb_pkg::IRQ_RESET;
         s_q.irq_mask <= ccb_pkg::IRQ_RESET;
         s_q.mode     <= ccb_pkg::CCB_RUN;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign axi_rsp.awready = ~s_q.aw_hold;
   assign axi_rsp.wready  = ~s_q.w_hold;
   assign axi_rsp.bvalid  = s_q.bvalid;
   assign axi_rsp.bresp   = s_q.bresp;
   assign axi_rsp.arready = ~s_q.rvalid;
   assign axi_rsp.rvalid  = s_q.rvalid;
   assign axi_rsp.rdata   = s_q.rdata;
   assign axi_rsp.rresp   = s_q.rresp;

   // events pass only while enabled, unblocked and frame-synchronised
   // the request bit itself gates too: it stands one cycle before the drain starts
   assign dma_event = evt_request & s_q.gate & s_q.ctrl[ccb_pkg::EN_BIT] & ~blocked &
                      (s_q.mode == ccb_pkg::CCB_RUN) & ~s_q.ctrl[ccb_pkg::REQ_BIT] &
                      ~fld_rise;
   assign fifo_flush             = s_q.flush | blocked;
   assign capture_channel_enable = s_q.ctrl[ccb_pkg::EN_BIT];
   assign capture_b_control_reg  = s_q.ctrl;
   assign irq                    = |(s_q.irq_stat & s_q.irq_mask);

endmodule : ccb_ctrl

// ---- hdl/ccb_pkg.sv ----
// package: register map, field positions, types and states of the capture channel b control block
package ccb_pkg;
   localparam logic [7:0]  CTRL_OFS      = 8'h00;
   localparam logic [7:0]  STAT_OFS      = 8'h04;
   localparam logic [7:0]  IRQ_STAT_OFS  = 8'h08;
   localparam logic [7:0]  IRQ_MASK_OFS  = 8'h0c;
   localparam int          REQ_BIT       = 31;
   localparam int          BLK_BIT       = 30;
   localparam int          EN_BIT        = 15;
   localparam logic [31:0] CTRL_RESET    = 32'h4002_0030;
   localparam logic [31:0] CTRL_WMASK    = 32'h4013_9df3;
   localparam logic [2:0]  STAT_RESET    = 3'h0;
   localparam logic [3:0]  IRQ_RESET     = 4'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // gray sequence along the usual path
   typedef enum logic [1:0] {
      CCB_RUN   = 2'h0,
      CCB_DRAIN = 2'h1,
      CCB_FLUSH = 2'h3,
      CCB_WAIT  = 2'h2
   } ccb_mode_t;

   typedef struct packed {
      logic f1_done;
      logic f2_done;
      logic frm_done;
      logic vert;
   } ccb_evt_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } ccb_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ccb_axi_rsp_t;
endpackage : ccb_pkg

// ---- hdl/ccb_sync.sv ----
// file: two-stage synchroniser for the video timing pins
`timescale 1ns/100ps
module ccb_sync #(
   parameter int W = 2
) (
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : ccb_sync

// ---- tb/capture_channel_b_control_tb.sv ----
// testbench: bus, blocking, interrupt and channel reset scenarios
`timescale 1ns/100ps
module capture_channel_b_control_tb;
   ccb_pkg::ccb_axi_req_t req;
   ccb_pkg::ccb_axi_rsp_t rsp;
   ccb_pkg::ccb_evt_t     cap_evt;
   logic                  core_clk, nrst, frame_start, field_start, evt_request;
   logic                  dma_pending, dma_event, fifo_flush, en, irq;
   logic [31:0]           ctrl, d;
   logic [1:0]            r;
   logic [3:0]            lat;
   int                    failures, n_checks;
   ccb_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
      .frame_start(frame_start), .field_start(field_start), .cap_evt(cap_evt),
      .dma_pending(dma_pending), .evt_request(evt_request), .dma_event(dma_event),
      .fifo_flush(fifo_flush), .capture_channel_enable(en), .capture_b_control_reg(ctrl),
      .irq(irq));
   ccb_dma_model u_dma (.core_clk(core_clk), .nrst(nrst), .dma_event(dma_event), .lat(lat),
      .dma_pending(dma_pending));
   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // bready and rready stay high, so back-to-back calls never reassign them
   task wr(input logic [7:0] a, input logic [31:0] v);
      logic ad, wd;
      ad = 0;
      wd = 0;
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= v;
      forever begin
         @(posedge core_clk);
         if (ad && wd && rsp.bvalid) break;
         if (!ad && rsp.awready) begin
            ad = 1;
            req.awvalid <= 1'b0;
         end
         if (!wd && rsp.wready) begin
            wd = 1;
            req.wvalid <= 1'b0;
         end
      end
      r = rsp.bresp;
   endtask : wr
   task rd(input logic [7:0] a);
      logic t;
      t = 0;
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      forever begin
         @(posedge core_clk);
         if (t && rsp.rvalid) break;
         if (!t && rsp.arready) begin
            t = 1;
            req.arvalid <= 1'b0;
         end
      end
      d = rsp.rdata;
      r = rsp.rresp;
   endtask : rd
   task try_dma(input logic e);
      evt_request <= 1'b1;
      @(posedge core_clk);
      chk({31'h0, dma_event}, {31'h0, e});
      evt_request <= 1'b0;
   endtask : try_dma
   task pin(input logic fr);
      if (fr) frame_start <= 1'b1; else field_start <= 1'b1;
      repeat (6) @(posedge core_clk);
      frame_start <= 1'b0;
      field_start <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask : pin
   task irq_is(input logic e);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask : irq_is
   ////////////////////////////////////////////////////////////
   task t_blk;
      rd(ccb_pkg::CTRL_OFS);
      chk(d, ccb_pkg::CTRL_RESET);
      chk({31'h0, fifo_flush}, 32'h1);
      wr(ccb_pkg::IRQ_MASK_OFS, 32'hf);
      cap_evt <= 4'hf;
      @(posedge core_clk);
      cap_evt <= 4'h0;
      rd(ccb_pkg::STAT_OFS);
      chk(d, 32'h0);
      irq_is(1'b0);
      try_dma(1'b0);
      wr(ccb_pkg::CTRL_OFS, (ccb_pkg::CTRL_RESET & ~32'h4000_0000) | 32'h0000_8000);
      wr(ccb_pkg::STAT_OFS, 32'h7);
      try_dma(1'b0);
      pin(1'b0);
      try_dma(1'b0);
      pin(1'b1);
      try_dma(1'b1);
   endtask : t_blk
   task t_irq;
      cap_evt <= 4'h1;
      @(posedge core_clk);
      cap_evt <= 4'h0;
      irq_is(1'b1);
      wr(ccb_pkg::IRQ_MASK_OFS, 32'h0);
      irq_is(1'b0);
      wr(ccb_pkg::IRQ_MASK_OFS, 32'hf);
      irq_is(1'b1);
      rd(ccb_pkg::IRQ_STAT_OFS);
      chk(d, 32'h1);
      irq_is(1'b0);
   endtask : t_irq
   task t_chr;
      logic [31:0] v;
      lat <= 4'hc;
      rd(ccb_pkg::CTRL_OFS);
      v = d;
      wr(ccb_pkg::CTRL_OFS, v);
      chk({30'h0, r}, {30'h0, ccb_pkg::RESP_OKAY});
      rd(ccb_pkg::CTRL_OFS);
      chk(d, v);
      try_dma(1'b1);
      wr(ccb_pkg::CTRL_OFS, v | 32'h8000_0000);
      try_dma(1'b0);
      for (int i = 0; i < 40; i++) begin
         rd(ccb_pkg::CTRL_OFS);
         if (!d[31]) break;
      end
      chk(d, ccb_pkg::CTRL_RESET);
      chk({31'h0, en}, 32'h0);
      rd(ccb_pkg::IRQ_MASK_OFS);
      chk(d, 32'h0);
      rd(8'h10);
      chk({30'h0, r}, {30'h0, ccb_pkg::RESP_SLVERR});
      chk(d, 32'h0);
      wr(8'h10, 32'h0);
      chk({30'h0, r}, {30'h0, ccb_pkg::RESP_SLVERR});
   endtask : t_chr
   task give_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   initial begin
      core_clk = 0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      give_verdict;
   end
   initial begin
      nrst = 0;
      req = '0;
      req.wstrb = 4'hf;
      req.bready = 1;
      req.rready = 1;
      frame_start = 0;
      field_start = 0;
      cap_evt = '0;
      evt_request = 0;
      lat = 4'h1;
      failures = 0;
      n_checks = 0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_blk;
      t_irq;
      t_chr;
      give_verdict;
   end
endmodule : capture_channel_b_control_tb

// ---- tb/ccb_ctrl_monitor.sv ----
// checker: concurrent assertions on the capture control block ports
`timescale 1ns/100ps
module ccb_ctrl_monitor (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        dma_pending,
   input wire logic        dma_event,
   input wire logic        fifo_flush,
   input wire logic        capture_channel_enable,
   input wire logic [31:0] capture_b_control_reg,
   input wire logic        irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire rq = capture_b_control_reg[31];
   wire bk = capture_b_control_reg[30];
   ////////////////////////////////////////////////////////////
   // a pending request with no transfer outstanding must finish in a few cycles
   sequence s_rq_idle; rq && !dma_pending; endsequence
   sequence s_rq_gone; ##[1:5] !rq; endsequence
   a_blk_no_dma: assert property (bk |-> !dma_event) else $error("dma event while blocked");
   a_blk_flush: assert property (bk |-> fifo_flush) else $error("fifo not held");
   a_rst_no_dma: assert property (rq |-> !dma_event) else $error("dma event in reset");
   a_flush_after: assert property (rq && !bk && fifo_flush |-> !dma_pending)
      else $error("flush with transfers pending");
   a_rst_clr_en: assert property ($rose(rq) |=> !capture_channel_enable)
      else $error("enable kept");
   a_rst_restore: assert property ($fell(rq) |-> capture_b_control_reg == ccb_pkg::CTRL_RESET)
      else $error("control not restored");
   a_rst_done: assert property (s_rq_idle |-> s_rq_gone) else $error("request stuck");
   a_blk_no_irq: assert property (bk && $past(bk) |-> !$rose(irq)) else $error("irq blocked");
   a_clr_wait: assert property ($fell(bk) |-> (!dma_event) [*8])
      else $error("dma event in clear field");
endmodule : ccb_ctrl_monitor
bind ccb_ctrl ccb_ctrl_monitor u_mon (.core_clk(core_clk), .nrst(nrst),
   .dma_pending(dma_pending), .dma_event(dma_event), .fifo_flush(fifo_flush),
   .capture_channel_enable(capture_channel_enable),
   .capture_b_control_reg(capture_b_control_reg), .irq(irq));

// ---- tb/ccb_dma_model.sv ----
// partner: dma controller, busy for lat cycles after each event
`timescale 1ns/100ps
module ccb_dma_model (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       dma_event,
   input  wire logic [3:0] lat,
   output logic            dma_pending
);
   logic [3:0] cnt_q;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) cnt_q <= 4'h0;
      else if (dma_event) cnt_q <= lat;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
   end
   assign dma_pending = (cnt_q != 4'h0);
endmodule : ccb_dma_model
